// ### rtl/clock_select_pkg.sv
// Shared constants and types for the clock select and time base block.
// Assumes a single 100 MHz bus clock and an AXI4-Lite register master.
package clock_select_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAIT_CERAMIC_NS = 10000000; // 10 ms
    localparam int WAIT_RC_NS = 300000;        // 300 us
    // Least times round up to whole cycles
    localparam int WAIT_CERAMIC_CYC = (WAIT_CERAMIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_RC_CYC = (WAIT_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W = 24;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [7:0] IDX_FAST_TAPS = 8'h60;
    localparam logic [7:0] IDX_SLOW_TAPS = 8'h61;
    localparam logic [7:0] IDX_FREQ_CTRL = 8'h62;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h63;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h64;
    localparam logic [7:0] IDX_CLK_STATUS = 8'h65;
    localparam int ADDR_W = 12;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int FC_SYSCLK_SEL = 0;
    localparam int FC_HS_OSC_EN = 1;
    localparam int FC_OSC_TYPE = 2;
    localparam logic [3:0] FREQ_CTRL_RST = 4'h0;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam int CS_HS_READY = 0;
    localparam int CS_SYSCLK_IS_HS = 1;

    // Counter geometry
    localparam int TICK_W = 15;
    localparam logic [TICK_W-1:0] TICK_RST = 15'h0000;
    localparam int TAP_128 = 7;   // Fast taps are bits 10..7
    localparam int TAP_8 = 11;    // Slow taps are bits 14..11
    localparam int TAP_32 = 9;
    localparam int TAP_16 = 10;
    localparam int TAP_4 = 12;
    localparam int TAP_2 = 13;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic osc_type_select;
        logic hs_osc_enable;
        logic sysclk_select;
    } freq_ctrl_t;

    // Request group 4: bit3 32 Hz, bit2 16 Hz, bit1 4 Hz, bit0 2 Hz
    typedef struct packed {
        logic req_tick_32;
        logic req_tick_16;
        logic req_tick_4;
        logic req_tick_2;
    } irq_request_group4_t;

    typedef struct packed {
        logic [3:0] slow;
        logic [3:0] fast;
    } taps_t;

    typedef enum logic [1:0] {
        MUX_RUN,
        MUX_PARK,
        MUX_TAKE
    } mux_state_t;

endpackage

// ### rtl/tick_counter.sv
// Fifteen-stage time base divider with tap reads, clears and falling-edge events.
// Assumes the low-speed clock arrives already synchronised to CLK.
`timescale 1ns/1ns
module tick_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Synchronised low-speed clock level
    input wire logic ls_level,
    // Divider clears, one-cycle pulses
    input wire logic clr_slow,
    input wire logic clr_fast,
    // Taps and events
    output clock_select_pkg::taps_t taps,
    output clock_select_pkg::irq_request_group4_t falls
);

    // ************************************************************
    // Counter
    // ************************************************************
    logic [clock_select_pkg::TICK_W-1:0] cnt_reg;
    logic [clock_select_pkg::TICK_W-1:0] cnt_next;
    logic ls_prev_reg;

    // Next count: clear beats the count step, so a tap never glitches high
    always_comb begin
        cnt_next = cnt_reg;
        if (ls_prev_reg && !ls_level) begin
            cnt_next = cnt_reg + 15'h0001;
        end
        if (clr_fast) begin
            cnt_next[clock_select_pkg::TAP_2+1:clock_select_pkg::TAP_128] = 8'h00;
        end else if (clr_slow) begin
            cnt_next[clock_select_pkg::TAP_2+1:clock_select_pkg::TAP_8] = 4'h0;
        end
    end

    // Count register; runs from reset with no software start
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg <= clock_select_pkg::TICK_RST;
            ls_prev_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ls_prev_reg <= ls_level;
        end
    end

    // ************************************************************
    // Taps and events
    // ************************************************************
    // Tap read data
    always_comb begin
        taps.fast = cnt_reg[clock_select_pkg::TAP_16:clock_select_pkg::TAP_128];
        taps.slow = cnt_reg[clock_select_pkg::TAP_2+1:clock_select_pkg::TAP_8];
    end

    // A one-to-zero step, whether counted or forced by a clear, is an event
    always_comb begin
        falls.req_tick_32 = cnt_reg[clock_select_pkg::TAP_32] & ~cnt_next[clock_select_pkg::TAP_32];
        falls.req_tick_16 = cnt_reg[clock_select_pkg::TAP_16] & ~cnt_next[clock_select_pkg::TAP_16];
        falls.req_tick_4 = cnt_reg[clock_select_pkg::TAP_4] & ~cnt_next[clock_select_pkg::TAP_4];
        falls.req_tick_2 = cnt_reg[clock_select_pkg::TAP_2] & ~cnt_next[clock_select_pkg::TAP_2];
    end

endmodule

// ### rtl/sysclk_mux.sv
// Glitch-free selector between the low-speed and high-speed clock levels.
// Assumes both levels are synchronised to CLK; output is a registered level.
`timescale 1ns/1ns
module sysclk_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Sources and request
    input wire logic ls_level,
    input wire logic hs_level,
    input wire logic want_hs,
    // Result
    output logic sysclk,
    output logic on_hs
);

    clock_select_pkg::mux_state_t state_reg;
    logic on_hs_reg;
    logic out_reg;
    logic cur_level;

    assign cur_level = on_hs_reg ? hs_level : ls_level;

    // ************************************************************
    // Switch sequence
    // ************************************************************
    // Park the output low on the old source, then take the new one only while it
    // is low, so no shortened high or low phase ever leaves the block
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= clock_select_pkg::MUX_RUN;
            on_hs_reg <= 1'b0;
        end else begin
            case (state_reg)
                clock_select_pkg::MUX_RUN: begin
                    if (want_hs != on_hs_reg && !cur_level) begin
                        state_reg <= clock_select_pkg::MUX_PARK;
                    end
                end
                clock_select_pkg::MUX_PARK: begin
                    if (want_hs == on_hs_reg) begin
                        state_reg <= clock_select_pkg::MUX_RUN;
                    end else if (!(want_hs ? hs_level : ls_level)) begin
                        on_hs_reg <= want_hs;
                        state_reg <= clock_select_pkg::MUX_TAKE;
                    end
                end
                clock_select_pkg::MUX_TAKE: begin
                    state_reg <= clock_select_pkg::MUX_RUN;
                end
                default: begin
                    state_reg <= clock_select_pkg::MUX_RUN;
                end
            endcase
        end
    end

    // Output level, held low while parked
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_reg <= 1'b0;
        end else if (state_reg == clock_select_pkg::MUX_RUN && !(want_hs != on_hs_reg && !cur_level)) begin
            out_reg <= cur_level;
        end else begin
            out_reg <= 1'b0;
        end
    end

    assign sysclk = out_reg;
    assign on_hs = on_hs_reg;

endmodule

// ### rtl/clock_select_top.sv
// Clock select, high-speed oscillator control and time base with interrupts.
// Assumes an AXI4-Lite master on CLK and the two clock pins from outside.
//
// What this block does
// - Frequency control bit 2 picks RC (0) or ceramic (1); resets to 0.
// - Bit 0 picks system clock: 0 low-speed, 1 high-speed; resets to 0.
// - Bit 1 starts (1) or stops (0) the high-speed oscillator; resets to 0.
// - The low-speed crystal clock keeps running always, even on high-speed.
// - Enabling starts the oscillator in the mode the type bit currently gives.
// - Returning from high-speed to low-speed clock needs no wait.
// - Fifteen-bit tick counter advances on each falling edge of 32.768 kHz.
// - Reset clears the tick counter; counting then starts by itself.
// - Falls of 32, 16, 4, 2 Hz taps set request bits 3, 2, 1, 0.
// - Tap reads: fast register 16..128 Hz, slow register 1..8 Hz, bits 3..0.
// - Slow write clears 1-8 Hz stages; fast write clears all eight stages.
// - Tap register writes clear stages whatever the written data.
// - A clear dropping a set 32/16/4/2 Hz tap raises that request too.
// - Request group clears at reset; accepting an interrupt clears its bit.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module clock_select_top #(
    parameter int WAIT_CERAMIC_CYC = clock_select_pkg::WAIT_CERAMIC_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // AXI4-Lite write address
    input wire logic [clock_select_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [clock_select_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Clock pins from the oscillators
    input wire logic LS_CLK_IN,
    input wire logic HS_CLK_IN,
    // Oscillator controls
    output logic LS_OSC_RUN,
    output logic HS_OSC_ENABLE,
    output logic OSC_TYPE_CERAMIC,
    // System clock
    output logic SYSCLK_OUT,
    output logic SYSCLK_ON_HS,
    // Interrupt side
    input wire logic [3:0] IRQ_ACCEPT,
    output logic [3:0] IRQ_REQ_GROUP4,
    output logic IRQ
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Word index of a byte address; address bit 11 makes it unmapped, bit 10 is ignored
    function automatic logic [8:0] word_index(input logic [clock_select_pkg::ADDR_W-1:0] a);
        word_index = {a[clock_select_pkg::ADDR_W-1], a[9:2]};
    endfunction

    function automatic logic hits(input logic [8:0] idx, input logic [7:0] reg_idx);
        hits = (idx == {1'b0, reg_idx});
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic ls_meta_reg;
    logic ls_sync_reg;
    logic hs_meta_reg;
    logic hs_sync_reg;

    // Two flops each; only the second is read by logic
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ls_meta_reg <= 1'b0;
            ls_sync_reg <= 1'b0;
            hs_meta_reg <= 1'b0;
            hs_sync_reg <= 1'b0;
        end else begin
            ls_meta_reg <= LS_CLK_IN;
            ls_sync_reg <= ls_meta_reg;
            hs_meta_reg <= HS_CLK_IN;
            hs_sync_reg <= hs_meta_reg;
        end
    end

    // ************************************************************
    // AXI4-Lite write path
    // ************************************************************
    logic aw_held_reg;
    logic w_held_reg;
    logic [clock_select_pkg::ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic wr_fire;
    logic [8:0] wr_idx;
    logic wr_mapped;

    // Address and data are taken in either order; a held item blocks its own channel
    assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
    assign S_AXI_WREADY = !w_held_reg && !bvalid_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_idx = word_index(awaddr_reg);
    assign wr_mapped = hits(wr_idx, clock_select_pkg::IDX_FAST_TAPS) || hits(wr_idx, clock_select_pkg::IDX_SLOW_TAPS)
        || hits(wr_idx, clock_select_pkg::IDX_FREQ_CTRL) || hits(wr_idx, clock_select_pkg::IDX_IRQ_STATUS)
        || hits(wr_idx, clock_select_pkg::IDX_IRQ_MASK) || hits(wr_idx, clock_select_pkg::IDX_CLK_STATUS);

    // Capture of address and data halves
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= S_AXI_AWADDR;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response, one cycle after both halves are in
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= clock_select_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? clock_select_pkg::RESP_OKAY : clock_select_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;

    // Per-register write strobes; only byte lane 0 carries data
    logic wr_lane0;
    logic clr_fast;
    logic clr_slow;
    assign wr_lane0 = wr_fire && wstrb_reg[0];
    assign clr_fast = wr_fire && hits(wr_idx, clock_select_pkg::IDX_FAST_TAPS);
    assign clr_slow = wr_fire && hits(wr_idx, clock_select_pkg::IDX_SLOW_TAPS);

    // ************************************************************
    // Frequency control and oscillator
    // ************************************************************
    clock_select_pkg::freq_ctrl_t fc_reg;

    // Software-owned control bits, all zero after reset
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            fc_reg <= clock_select_pkg::FREQ_CTRL_RST[2:0];
        end else if (wr_lane0 && hits(wr_idx, clock_select_pkg::IDX_FREQ_CTRL)) begin
            fc_reg.osc_type_select <= wdata_reg[clock_select_pkg::FC_OSC_TYPE];
            fc_reg.hs_osc_enable <= wdata_reg[clock_select_pkg::FC_HS_OSC_EN];
            fc_reg.sysclk_select <= wdata_reg[clock_select_pkg::FC_SYSCLK_SEL];
        end
    end

    // Oscillator drive follows the current type bit, so enabling starts that mode
    assign HS_OSC_ENABLE = fc_reg.hs_osc_enable;
    assign OSC_TYPE_CERAMIC = fc_reg.osc_type_select;
    assign LS_OSC_RUN = 1'b1;

    // Settle timer: tells software when the documented wait has passed.
    // It only reports; the select bit is not gated, software keeps the wait.
    logic [clock_select_pkg::WAIT_W-1:0] settle_reg;
    logic hs_ready_reg;
    logic [clock_select_pkg::WAIT_W-1:0] settle_goal;
    assign settle_goal = fc_reg.osc_type_select ? clock_select_pkg::WAIT_W'(WAIT_CERAMIC_CYC)
        : clock_select_pkg::WAIT_W'(clock_select_pkg::WAIT_RC_CYC);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            settle_reg <= '0;
            hs_ready_reg <= 1'b0;
        end else if (!fc_reg.hs_osc_enable) begin
            settle_reg <= '0;
            hs_ready_reg <= 1'b0;
        end else if (settle_reg >= settle_goal - 1'b1) begin
            hs_ready_reg <= 1'b1;
        end else begin
            settle_reg <= settle_reg + 1'b1;
        end
    end

    // ************************************************************
    // System clock selection
    // ************************************************************
    sysclk_mux u_mux (
        .clk(CLK),
        .rst_b(RST_B),
        .ls_level(ls_sync_reg),
        .hs_level(hs_sync_reg),
        .want_hs(fc_reg.sysclk_select),
        .sysclk(SYSCLK_OUT),
        .on_hs(SYSCLK_ON_HS)
    );

    // ************************************************************
    // Time base
    // ************************************************************
    clock_select_pkg::taps_t taps;
    clock_select_pkg::irq_request_group4_t falls;

    tick_counter u_tick (
        .clk(CLK),
        .rst_b(RST_B),
        .ls_level(ls_sync_reg),
        .clr_slow(clr_slow),
        .clr_fast(clr_fast),
        .taps(taps),
        .falls(falls)
    );

    // ************************************************************
    // Request group 4 and mask
    // ************************************************************
    logic [3:0] req_reg;
    logic [3:0] mask_reg;
    logic [3:0] req_clear;
    assign req_clear = (wr_lane0 && hits(wr_idx, clock_select_pkg::IDX_IRQ_STATUS) ? wdata_reg[3:0] : 4'h0)
        | IRQ_ACCEPT;

    // Sticky requests; a new event in the clearing cycle survives
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            req_reg <= clock_select_pkg::IRQ_RST;
        end else begin
            req_reg <= (req_reg & ~req_clear) | falls;
        end
    end

    // Mask register, same layout as the requests
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            mask_reg <= clock_select_pkg::IRQ_RST;
        end else if (wr_lane0 && hits(wr_idx, clock_select_pkg::IDX_IRQ_MASK)) begin
            mask_reg <= wdata_reg[3:0];
        end
    end

    assign IRQ_REQ_GROUP4 = req_reg;
    assign IRQ = |(req_reg & mask_reg);

    // ************************************************************
    // AXI4-Lite read path
    // ************************************************************
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [8:0] rd_idx;
    logic [3:0] rd_val;
    logic rd_ok;

    assign S_AXI_ARREADY = !rvalid_reg;
    assign rd_idx = word_index(S_AXI_ARADDR);

    // Read decode; upper bits of every word read as zero
    always_comb begin
        rd_val = 4'h0;
        rd_ok = 1'b1;
        if (hits(rd_idx, clock_select_pkg::IDX_FAST_TAPS)) begin
            rd_val = taps.fast;
        end else if (hits(rd_idx, clock_select_pkg::IDX_SLOW_TAPS)) begin
            rd_val = taps.slow;
        end else if (hits(rd_idx, clock_select_pkg::IDX_FREQ_CTRL)) begin
            rd_val = {1'b0, fc_reg};
        end else if (hits(rd_idx, clock_select_pkg::IDX_IRQ_STATUS)) begin
            rd_val = req_reg;
        end else if (hits(rd_idx, clock_select_pkg::IDX_IRQ_MASK)) begin
            rd_val = mask_reg;
        end else if (hits(rd_idx, clock_select_pkg::IDX_CLK_STATUS)) begin
            rd_val[clock_select_pkg::CS_HS_READY] = hs_ready_reg;
            rd_val[clock_select_pkg::CS_SYSCLK_IS_HS] = SYSCLK_ON_HS;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= clock_select_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {28'h0000000, rd_val};
            rresp_reg <= rd_ok ? clock_select_pkg::RESP_OKAY : clock_select_pkg::RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;

endmodule

// ### tb/csel_props.sv
// Assertions on the clock select block's ports.
// Bound from tb onto the top module; sees only its ports.
`timescale 1ns/1ns
module csel_props (
    // Clock, reset, bus handshakes
    input wire logic CLK, RST_B, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
    input wire logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
    // Oscillator, clock and interrupt outputs
    input wire logic LS_OSC_RUN, HS_OSC_ENABLE, OSC_TYPE_CERAMIC, SYSCLK_OUT, SYSCLK_ON_HS, IRQ,
    input wire logic [3:0] IRQ_REQ_GROUP4
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Reset is the cause here, so it cannot disable itself
    chk_reset_clear:
    assert property (disable iff (1'b0) !RST_B |=> !HS_OSC_ENABLE && !OSC_TYPE_CERAMIC && !SYSCLK_ON_HS
        && IRQ_REQ_GROUP4 == 4'h0) else $error("reset state wrong");
    chk_crystal_runs:
    assert property (LS_OSC_RUN) else $error("crystal stopped");
    // A source change only while the output sits parked low
    chk_switch_parked:
    assert property ($changed(SYSCLK_ON_HS) |-> !SYSCLK_OUT && !$past(SYSCLK_OUT)) else $error("switch unparked");
    chk_irq_cause:
    assert property (IRQ |-> IRQ_REQ_GROUP4 != 4'h0) else $error("irq without request");
    chk_write_answer:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID)
        else $error("write not answered");
    chk_write_once:
    assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("write answer repeated");
    chk_read_answer:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read not answered");
    chk_read_refused:
    assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while pending");
endmodule

// ### tb/osc_parts.sv
// Model of the crystal and high-speed resonator parts.
// Delays in ns; crystal rate scaled up to keep the run short.
`timescale 1ns/1ns
module osc_parts #(parameter int LS_HALF = 43, parameter int HS_HALF = 17, parameter int CER_NS = 400) (
    // Controls
    input wire logic hs_en,
    input wire logic ceramic,
    // Pins
    output logic ls_clk,
    output logic hs_clk
);
    // Crystal never stops
    initial begin
        ls_clk = 1'b0;
        forever #(LS_HALF) ls_clk = ~ls_clk;
    end
    // Starts in the selected mode, ceramic settles slowly; stopped pin rests low
    initial begin
        hs_clk = 1'b0;
        forever begin
            wait (hs_en === 1'b1);
            #(ceramic ? CER_NS : 20);
            while (hs_en === 1'b1) #(HS_HALF) hs_clk = ~hs_clk;
            hs_clk = 1'b0;
        end
    end
endmodule

// ### tb/tb.sv
// Register-level tests of the clock select block.
// Assumes package, design, checker and oscillator model compiled first.
`timescale 1ns/1ns
module tb;
    logic CLK, RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, IRQ;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, LS_CLK_IN, HS_CLK_IN;
    logic LS_OSC_RUN, HS_OSC_ENABLE, OSC_TYPE_CERAMIC, SYSCLK_OUT, SYSCLK_ON_HS;
    logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, q;
    logic [2:0] S_AXI_AWPROT, S_AXI_ARPROT;
    logic [3:0] S_AXI_WSTRB, IRQ_ACCEPT, IRQ_REQ_GROUP4;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
    int err_total = 0;
    int checked = 0;
    int n;
    localparam logic [11:0] A_FC = {2'h0, clock_select_pkg::IDX_FREQ_CTRL, 2'h0};
    localparam logic [11:0] A_FT = {2'h0, clock_select_pkg::IDX_FAST_TAPS, 2'h0};
    localparam logic [11:0] A_RQ = {2'h0, clock_select_pkg::IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] A_MK = {2'h0, clock_select_pkg::IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] A_CS = {2'h0, clock_select_pkg::IDX_CLK_STATUS, 2'h0};
    // Short ceramic settle keeps the run brief
    clock_select_top #(.WAIT_CERAMIC_CYC(50)) DUT (.*);
    osc_parts parts (.hs_en(HS_OSC_ENABLE), .ceramic(OSC_TYPE_CERAMIC), .ls_clk(LS_CLK_IN), .hs_clk(HS_CLK_IN));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One bus transfer; ready is sampled at the falling edge so the rising edge is race free
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic done;
        logic [2:0] rdy;
        done = 1'b0;
        @(posedge CLK);
        if (w) begin
            {S_AXI_AWADDR, S_AXI_WDATA} <= {a, d};
            {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        end else begin
            S_AXI_ARADDR <= a;
            {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        end
        for (int k = 0; k < 100 && !done; k++) begin
            @(negedge CLK);
            rdy = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY};
            done = w ? S_AXI_BVALID : S_AXI_RVALID;
            q = S_AXI_RDATA;
            r = w ? S_AXI_BRESP : S_AXI_RRESP;
            @(posedge CLK);
            {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} <= {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} & ~rdy;
            if (done) {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
        end
        if (!done) begin
            err_total++;
            stop_test();
        end
        @(negedge CLK);
    endtask
    initial begin
        {RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_AWPROT, S_AXI_ARPROT, IRQ_ACCEPT} = '0;
        S_AXI_WSTRB = 4'hf;
        repeat (10) @(posedge CLK);
        RST_B <= 1'b1;
        bus(0, A_FC, 0);
        check("freq_ctrl", q, 32'h0);
        check("requests", IRQ_REQ_GROUP4, 4'h0);
        bus(0, 12'h1a0, 0);
        check("unmapped", r, clock_select_pkg::RESP_SLVERR);
        bus(1, A_FC, 32'h6);
        check("osc pins", {OSC_TYPE_CERAMIC, HS_OSC_ENABLE}, 2'h3);
        check("wr resp", r, clock_select_pkg::RESP_OKAY);
        // Select high speed only once the resonator has settled
        for (n = 0; n < 50 && q[0] !== 1'b1; n++) bus(0, A_CS, 0);
        check("settled", q[0], 1'b1);
        bus(1, A_FC, 32'h7);
        for (n = 0; n < 300 && SYSCLK_ON_HS !== 1'b1; n++) @(negedge CLK);
        check("on fast", SYSCLK_ON_HS, 1'b1);
        bus(1, A_FC, 32'h6);
        for (n = 0; n < 300 && SYSCLK_ON_HS !== 1'b0; n++) @(negedge CLK);
        check("on slow", SYSCLK_ON_HS, 1'b0);
        bus(1, A_MK, 32'hf);
        for (n = 0; n < 20000 && IRQ_REQ_GROUP4 === 4'h0; n++) @(negedge CLK);
        check("first fall", {IRQ, IRQ_REQ_GROUP4}, 5'h18);
        bus(0, A_FT, 0);
        check("fast taps", q, 32'h8);
        bus(1, A_FT, 32'h5);
        check("clear raises", IRQ_REQ_GROUP4, 4'hc);
        bus(0, A_FT, 0);
        check("taps cleared", q, 32'h0);
        @(posedge CLK);
        IRQ_ACCEPT <= 4'h4;
        @(posedge CLK);
        IRQ_ACCEPT <= 4'h0;
        @(negedge CLK);
        check("accepted", IRQ_REQ_GROUP4, 4'h8);
        bus(1, A_RQ, 32'h8);
        check("cleared", {IRQ, IRQ_REQ_GROUP4}, 5'h0);
        bus(1, A_FC, 32'h0);
        bus(1, A_FC, 32'h2);
        bus(0, A_CS, 0);
        check("rc early", q[0], 1'b0);
        for (n = 0; n < 40 && q[0] !== 1'b1; n++) begin
            repeat (1000) @(negedge CLK);
            bus(0, A_CS, 0);
        end
        check("rc ready", q[0], 1'b1);
        bus(1, A_MK, 32'h0);
        bus(1, A_FT, 32'h0);
        bus(1, A_RQ, 32'hf);
        check("quiet", IRQ_REQ_GROUP4, 4'h0);
        stop_test();
    end
endmodule
bind clock_select_top csel_props props (.*);
